// ==== plp_delay.sv ====
// Loss delay counter with a held fault flag.
`timescale 1ns/1ps
module plp_delay #(
  parameter int W = 8
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic tick, // One delay unit has passed.
  input wire logic active, // Loss present and not suppressed.
  input wire logic [W-1:0] limit, // Delay in units.
  input wire logic clear, // Fault reset pulse.
  output logic fault // Held fault.
);
  logic [W-1:0] cnt_q;
  logic hit;

  assign hit = active && tick && ({1'b0, cnt_q} + 1'b1 >= {1'b0, limit});

  // Count whole units; any gap in the loss starts again from zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!active) begin
      cnt_q <= '0; // [RULE11]
    end else if (tick && cnt_q != {W{1'b1}}) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // A new hit wins over a simultaneous fault reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
    end else if (hit) begin
      fault <= 1'b1; // [RULE2] [RULE7]
    end else if (clear) begin
      fault <= 1'b0; // [RULE11]
    end
  end

  a_cnt_restart: assert property (@(posedge clk) disable iff (!rst_n)
    !active |=> cnt_q == '0) else $error("Delay count not restarted."); // [RULE11]
  a_fault_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fault) |-> $past(active && tick)) else $error("Fault without delay."); // [RULE2]
  a_fault_held: assert property (@(posedge clk) disable iff (!rst_n)
    fault && !clear |=> fault) else $error("Fault dropped."); // [RULE11]
endmodule

// ==== plp_minmax.sv ====
// Extreme value tracker forming the ripple of one interval.
`timescale 1ns/1ps
module plp_minmax #(
  parameter int W = 16
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic smp_valid, // Sample strobe.
  input wire logic [W-1:0] smp, // Bus voltage sample.
  input wire logic tick, // End of interval.
  output logic [W-1:0] ripple // Difference of the last interval.
);
  logic [W-1:0] max_q;
  logic [W-1:0] min_q;
  logic seen_q;

  // Track extremes; a sample on the tick opens the next interval.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      max_q <= '0;
      min_q <= '0;
      seen_q <= 1'b0;
    end else if (tick) begin
      max_q <= smp;
      min_q <= smp;
      seen_q <= smp_valid;
    end else if (smp_valid) begin
      seen_q <= 1'b1;
      if (!seen_q || smp > max_q) max_q <= smp; // [RULE1]
      if (!seen_q || smp < min_q) min_q <= smp; // [RULE1]
    end
  end

  // An empty interval reports no ripple rather than stale extremes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ripple <= '0;
    end else if (tick) begin
      ripple <= seen_q ? max_q - min_q : '0; // [RULE1]
    end
  end

  a_max_ge_min: assert property (@(posedge clk) disable iff (!rst_n)
    seen_q |-> max_q >= min_q) else $error("Extremes out of order."); // [RULE1]
endmodule

// ==== plp_pkg.sv ====
// Shared constants for the phase loss protection block.
// What this block does
// RULE1: Ripple is max minus min per 1.28 s.
// RULE2: Ripple at or above level, delay, input fault.
// RULE3: Input level 1 to 100 percent, default 7.
// RULE4: Input delay 2 to 255 intervals, default 8.
// RULE5: Suppress input check: 100%, stop, contactor open.
// RULE6: Suppress input check: converter fault, decel, low current.
// RULE7: RMS at or below level, delay, output fault.
// RULE8: Output level 0 to 100 percent, default 0.
// RULE9: Output delay 0.0 to 2.0 s, 0.1 s steps.
// RULE10: Output level 0 or delay 0 disables output check.
// RULE11: Counters restart when the loss drops; faults held until reset.
package plp_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_IN_LEVEL = 8'h00;
  localparam logic [7:0] OFF_IN_DELAY = 8'h04;
  localparam logic [7:0] OFF_OUT_LEVEL = 8'h08;
  localparam logic [7:0] OFF_OUT_DELAY = 8'h0c;
  localparam logic [7:0] OFF_VIN_REF = 8'h10;
  localparam logic [7:0] OFF_I_RATED = 8'h14;
  localparam logic [7:0] OFF_RIPPLE = 8'h18;
  localparam logic [7:0] OFF_STATE = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_FAULT_CLR = 8'h28;
  // Reset values and ranges of the settings.
  localparam logic [6:0] IN_LEVEL_RST = 7'd7;
  localparam logic [6:0] IN_LEVEL_MIN = 7'd1;
  localparam logic [6:0] LEVEL_MAX = 7'd100;
  localparam logic [7:0] IN_DELAY_RST = 8'd8;
  localparam logic [7:0] IN_DELAY_MIN = 8'd2;
  localparam logic [6:0] OUT_LEVEL_RST = 7'd0;
  localparam logic [4:0] OUT_DELAY_RST = 5'd2;
  localparam logic [4:0] OUT_DELAY_MAX = 5'd20;
  localparam logic [15:0] VIN_REF_RST = 16'h0400;
  localparam logic [15:0] I_RATED_RST = 16'h0400;
  // Scale factors for the percentage compares.
  localparam logic [23:0] PCT = 24'd100;
  localparam logic [63:0] PCT_SQ = 64'd10000;
  localparam logic [63:0] PHASES = 64'd3;
  localparam logic [63:0] LOW_I_NUM = 64'd27;
  // Timing: interval and output delay step, in ms, at 200 MHz.
  localparam int CLK_KHZ = 200000;
  localparam int INTERVAL_MS = 1280;
  localparam int OUT_STEP_MS = 100;
  localparam int INTERVAL_CYC = INTERVAL_MS * CLK_KHZ;
  localparam int OUT_STEP_CYC = OUT_STEP_MS * CLK_KHZ;
endpackage

// ==== plp_top.sv ====
// Input and output phase loss supervisor with an APB register file.
`timescale 1ns/1ps
module plp_top #(
  parameter int VW = 16,
  parameter int IW = 16,
  parameter int RMS_LOG2 = 6,
  parameter int INTERVAL_CYCLES = plp_pkg::INTERVAL_CYC,
  parameter int OUT_STEP_CYCLES = plp_pkg::OUT_STEP_CYC
) (
  input wire logic SYS_CLK, // System clock, 200 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB access phase.
  input wire logic PWRITE, // APB direction, high for write.
  input wire logic [7:0] PADDR, // APB byte address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready.
  output logic PSLVERR, // APB error on unmapped address.
  input wire logic VBUS_VALID, // Bus voltage sample strobe.
  input wire logic [VW-1:0] VBUS, // Bus voltage sample.
  input wire logic I_VALID, // Phase current sample strobe.
  input wire logic signed [IW-1:0] IA, // Phase A current.
  input wire logic signed [IW-1:0] IB, // Phase B current.
  input wire logic signed [IW-1:0] IC, // Phase C current.
  input wire logic STOP_CMD, // Stop command present.
  input wire logic MAIN_CONTACTOR, // Main contactor closed.
  input wire logic CONVERTER_FAULT, // Converter fault.
  input wire logic DECEL, // Drive decelerating.
  output logic INPUT_PHASE_FAULT, // Input phase fault, held.
  output logic OUTPUT_PHASE_FAULT, // Output phase fault, held.
  output logic COAST_STOP, // Coast the motor to stop.
  output logic IRQ // Interrupt, level.
);
  import plp_pkg::*;

  localparam int SQW = 2 * IW + 2;
  localparam int ACW = SQW + RMS_LOG2;

  logic [6:0] in_level_q;
  logic [7:0] in_delay_q;
  logic [6:0] out_level_q;
  logic [4:0] out_delay_q;
  logic [15:0] vin_ref_q;
  logic [15:0] i_rated_q;
  logic [1:0] irq_sts_q;
  logic [1:0] irq_mask_q;
  logic fault_clr_q;
  logic [31:0] ivl_cnt_q;
  logic [31:0] stp_cnt_q;
  logic ivl_tick;
  logic stp_tick;
  logic [VW-1:0] ripple;
  logic [ACW-1:0] acc_q;
  logic [RMS_LOG2-1:0] nsmp_q;
  logic [SQW-1:0] ms3_q;
  logic [SQW-1:0] sq_sum;
  logic in_loss;
  logic low_cur;
  logic in_supp;
  logic in_active;
  logic out_loss;
  logic out_supp;
  logic out_active;
  logic in_fault;
  logic out_fault;
  logic in_fault_d1_q;
  logic out_fault_d1_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [31:0] rd_d;
  logic [63:0] i_rated_sq;

  //////////////////////////////////////////////////////////////////////////
  // Time base.

  // The interval tick paces both the extreme tracker and the input delay.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ivl_cnt_q <= '0;
    end else if (ivl_tick) begin
      ivl_cnt_q <= '0;
    end else begin
      ivl_cnt_q <= ivl_cnt_q + 32'h1;
    end
  end
  assign ivl_tick = ivl_cnt_q == 32'(INTERVAL_CYCLES - 1); // [RULE1]

  // The step tick paces the output delay in tenths of a second.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stp_cnt_q <= '0;
    end else if (stp_tick) begin
      stp_cnt_q <= '0;
    end else begin
      stp_cnt_q <= stp_cnt_q + 32'h1;
    end
  end
  assign stp_tick = stp_cnt_q == 32'(OUT_STEP_CYCLES - 1); // [RULE9]

  //////////////////////////////////////////////////////////////////////////
  // Input phase check.

  plp_minmax #(.W(VW)) u_minmax (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .smp_valid(VBUS_VALID),
    .smp(VBUS),
    .tick(ivl_tick),
    .ripple(ripple)
  );

  // Compare in percent without a divider: ripple*100 against level*ref.
  assign in_loss = 24'(ripple) * PCT >= 24'(in_level_q) * 24'(vin_ref_q); // [RULE2]
  assign i_rated_sq = 64'(i_rated_q) * 64'(i_rated_q);
  // Thirty percent of rated: 3*Rms_output_current^2*100 <= 27*Ir^2.
  assign low_cur = 64'(ms3_q) * 64'(PCT) <= LOW_I_NUM * i_rated_sq; // [RULE6]
  assign in_supp = (in_level_q == LEVEL_MAX) || STOP_CMD || !MAIN_CONTACTOR // [RULE5]
    || CONVERTER_FAULT || DECEL || low_cur; // [RULE6]
  assign in_active = in_loss && !in_supp;

  plp_delay #(.W(8)) u_in_delay (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(ivl_tick),
    .active(in_active),
    .limit(in_delay_q),
    .clear(fault_clr_q),
    .fault(in_fault)
  );

  //////////////////////////////////////////////////////////////////////////
  // Output phase check.

  assign sq_sum = SQW'(IA * IA) + SQW'(IB * IB) + SQW'(IC * IC);

  // Mean of the summed squares over a block of samples gives 3*Rms_output_current^2;
  // the square root is avoided by squaring the other side instead.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= '0;
      nsmp_q <= '0;
      ms3_q <= '0;
    end else if (I_VALID) begin
      nsmp_q <= nsmp_q + 1'b1;
      if (nsmp_q == {RMS_LOG2{1'b1}}) begin
        ms3_q <= SQW'((acc_q + ACW'(sq_sum)) >> RMS_LOG2); // [RULE7]
        acc_q <= '0;
      end else begin
        acc_q <= acc_q + ACW'(sq_sum);
      end
    end
  end

  // Rms_output_current <= L% of Ir becomes 3*Rms_output_current^2*10000 <= 3*L^2*Ir^2.
  assign out_loss = 64'(ms3_q) * PCT_SQ
    <= PHASES * 64'(out_level_q) * 64'(out_level_q) * i_rated_sq; // [RULE7]
  assign out_supp = (out_level_q == 7'd0) || (out_delay_q == 5'd0); // [RULE10]
  assign out_active = out_loss && !out_supp;

  plp_delay #(.W(5)) u_out_delay (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(stp_tick),
    .active(out_active),
    .limit(out_delay_q),
    .clear(fault_clr_q),
    .fault(out_fault)
  );

  //////////////////////////////////////////////////////////////////////////
  // Fault outputs and interrupt.

  // Faults are re-registered so every output leaves from a flop here.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      INPUT_PHASE_FAULT <= 1'b0;
      OUTPUT_PHASE_FAULT <= 1'b0;
      COAST_STOP <= 1'b0;
      in_fault_d1_q <= 1'b0;
      out_fault_d1_q <= 1'b0;
    end else begin
      INPUT_PHASE_FAULT <= in_fault; // [RULE2]
      OUTPUT_PHASE_FAULT <= out_fault; // [RULE7]
      COAST_STOP <= in_fault || out_fault; // [RULE2] [RULE7]
      in_fault_d1_q <= in_fault;
      out_fault_d1_q <= out_fault;
    end
  end

  // Sticky event bits: a rising fault wins over a write-one clear.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q[0] <= (in_fault && !in_fault_d1_q) ||
        (irq_sts_q[0] && !(wr_en && PADDR == OFF_IRQ_STS && PWDATA[0]));
      irq_sts_q[1] <= (out_fault && !out_fault_d1_q) ||
        (irq_sts_q[1] && !(wr_en && PADDR == OFF_IRQ_STS && PWDATA[1]));
    end
  end

  // Interrupt line is one cycle behind the status it reflects.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_sts_q & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states.

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign mapped = PADDR[1:0] == 2'b00 && PADDR <= OFF_FAULT_CLR;

  // Settings are clamped into their legal range as they are written.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_level_q <= IN_LEVEL_RST; // [RULE3]
      in_delay_q <= IN_DELAY_RST; // [RULE4]
      out_level_q <= OUT_LEVEL_RST; // [RULE8]
      out_delay_q <= OUT_DELAY_RST; // [RULE9]
      vin_ref_q <= VIN_REF_RST;
      i_rated_q <= I_RATED_RST;
      irq_mask_q <= '0;
    end else if (wr_en) begin
      unique case (PADDR)
        OFF_IN_LEVEL: begin
          in_level_q <= PWDATA[31:0] < 32'(IN_LEVEL_MIN) ? IN_LEVEL_MIN :
            PWDATA[31:0] > 32'(LEVEL_MAX) ? LEVEL_MAX : PWDATA[6:0]; // [RULE3]
        end
        OFF_IN_DELAY: begin
          in_delay_q <= PWDATA[31:0] < 32'(IN_DELAY_MIN) ? IN_DELAY_MIN :
            PWDATA[31:8] != 24'h0 ? 8'hff : PWDATA[7:0]; // [RULE4]
        end
        OFF_OUT_LEVEL: begin
          out_level_q <= PWDATA[31:0] > 32'(LEVEL_MAX) ? LEVEL_MAX : PWDATA[6:0]; // [RULE8]
        end
        OFF_OUT_DELAY: begin
          out_delay_q <= PWDATA[31:0] > 32'(OUT_DELAY_MAX) ? OUT_DELAY_MAX :
            PWDATA[4:0]; // [RULE9]
        end
        OFF_VIN_REF: vin_ref_q <= PWDATA[15:0];
        OFF_I_RATED: i_rated_q <= PWDATA[15:0];
        OFF_IRQ_MASK: irq_mask_q <= PWDATA[1:0];
        default: begin
        end
      endcase
    end
  end

  // Fault reset is a one-cycle pulse from a write of one.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fault_clr_q <= 1'b0;
    end else begin
      fault_clr_q <= wr_en && PADDR == OFF_FAULT_CLR && PWDATA[0]; // [RULE11]
    end
  end

  // Read data is built in the setup cycle so it is a flop in the access.
  always_comb begin
    rd_d = 32'h0;
    unique case (PADDR)
      OFF_IN_LEVEL: rd_d = 32'(in_level_q);
      OFF_IN_DELAY: rd_d = 32'(in_delay_q);
      OFF_OUT_LEVEL: rd_d = 32'(out_level_q);
      OFF_OUT_DELAY: rd_d = 32'(out_delay_q);
      OFF_VIN_REF: rd_d = 32'(vin_ref_q);
      OFF_I_RATED: rd_d = 32'(i_rated_q);
      OFF_RIPPLE: rd_d = 32'(ripple);
      OFF_STATE: rd_d = {26'h0, out_supp, in_supp, out_fault, in_fault, out_loss, in_loss};
      OFF_IRQ_STS: rd_d = 32'(irq_sts_q);
      OFF_IRQ_MASK: rd_d = 32'(irq_mask_q);
      default: rd_d = 32'h0;
    endcase
  end

  // Ready never drops, so every access ends at its first edge with no wait state.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
      PREADY <= 1'b0;
    end else begin
      PREADY <= 1'b1;
      if (rd_en) PRDATA <= mapped ? rd_d : 32'h0;
      if (PSEL && !PENABLE) PSLVERR <= !mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  a_in_level_rng: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    in_level_q >= IN_LEVEL_MIN && in_level_q <= LEVEL_MAX) else $error("Bad in level."); // [RULE3]
  a_in_delay_rng: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    in_delay_q >= IN_DELAY_MIN) else $error("Bad in delay."); // [RULE4]
  a_out_lvl_rng: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    out_level_q <= LEVEL_MAX) else $error("Bad out level."); // [RULE8]
  a_out_dly_rng: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    out_delay_q <= OUT_DELAY_MAX) else $error("Bad out delay."); // [RULE9]
  a_in_suppress: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RULE5] [RULE6]
    (in_level_q == LEVEL_MAX || STOP_CMD || !MAIN_CONTACTOR || CONVERTER_FAULT || DECEL)
    |=> !$rose(in_fault)) else $error("Input check not suppressed.");
  a_out_suppress: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RULE10]
    (out_level_q == 7'd0 || out_delay_q == 5'd0) |=> !$rose(out_fault))
    else $error("Output check not suppressed.");
  a_coast_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (in_fault || out_fault) |=> COAST_STOP) else $error("No coast on fault."); // [RULE2]
  a_out_fault_pin: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RULE7]
    $rose(out_fault) |=> OUTPUT_PHASE_FAULT && irq_sts_q[1]) else $error("Out fault lost.");
endmodule

// ==== tb_phase_loss_protection.sv ====
// Self-checking testbench for the phase loss supervisor, driven over APB.
`timescale 1ns/1ps
module tb_phase_loss_protection;
  import plp_pkg::*;
  localparam int CEIL = 15000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, in_flt, out_flt, coast, irq;
  logic vvalid = 1'b0, ivalid = 1'b0, stop = 1'b0, contactor = 1'b1, conv = 1'b0, decel = 1'b0;
  logic tog = 1'b0, hi_i = 1'b1;
  logic [15:0] vbus = 16'h0, vamp = 16'h0;
  logic signed [15:0] ia = 16'sh0, ib = 16'sh0, ic = 16'sh0;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Short interval and step counts keep the run brief; expectations derive from them.
  plp_top #(.RMS_LOG2(2), .INTERVAL_CYCLES(100), .OUT_STEP_CYCLES(40)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .VBUS_VALID(vvalid), .VBUS(vbus), .I_VALID(ivalid), .IA(ia), .IB(ib), .IC(ic),
    .STOP_CMD(stop), .MAIN_CONTACTOR(contactor), .CONVERTER_FAULT(conv), .DECEL(decel),
    .INPUT_PHASE_FAULT(in_flt), .OUTPUT_PHASE_FAULT(out_flt), .COAST_STOP(coast), .IRQ(irq)
  );

  // Clock at 200 MHz.
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Samples every cycle; the bus voltage swings by vamp so the ripple equals vamp.
  always @(posedge clk) begin
    tog <= ~tog;
    vvalid <= 1'b1;
    ivalid <= 1'b1;
    vbus <= tog ? 16'd1000 + vamp : 16'd1000;
    ia <= hi_i ? 16'sd1000 : 16'sd0;
    ib <= hi_i ? -16'sd500 : 16'sd0;
    ic <= hi_i ? -16'sd500 : 16'sd0;
  end

  // A hang ends the run as a failure rather than running on forever.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the idle edge at the end keeps back-to-back calls race free.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Counts cycles until the chosen fault pin rises, then checks the count lies in [lo, hi].
  task automatic rise_in(input bit outp, input int lo, input int hi);
    int n;
    n = 0;
    while ((outp ? out_flt : in_flt) !== 1'b1 && n < hi + 10) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(OFF_IN_LEVEL, 32'd7);
    rdchk(OFF_IN_DELAY, 32'd8);
    rdchk(OFF_OUT_LEVEL, 32'd0);
    rdchk(OFF_OUT_DELAY, 32'd2);
    rdchk(OFF_IRQ_MASK, 32'd0);
    apb(1'b0, 8'h2c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset_values done");
    wr(OFF_IN_LEVEL, 32'd0);
    rdchk(OFF_IN_LEVEL, 32'd1);
    wr(OFF_IN_LEVEL, 32'd200);
    rdchk(OFF_IN_LEVEL, 32'd100);
    wr(OFF_IN_DELAY, 32'd1);
    rdchk(OFF_IN_DELAY, 32'd2);
    wr(OFF_OUT_LEVEL, 32'd101);
    rdchk(OFF_OUT_LEVEL, 32'd100);
    wr(OFF_OUT_DELAY, 32'd30);
    rdchk(OFF_OUT_DELAY, 32'd20);
    $display("test setting_ranges done");
    // Each suppression cause in turn, with a ripple that would otherwise trip quickly.
    wr(OFF_OUT_LEVEL, 32'd0);
    wr(OFF_IN_DELAY, 32'd2);
    // A low reference keeps the ripple a loss even at the full-scale level setting.
    wr(OFF_VIN_REF, 32'd64);
    vamp <= 16'd100;
    for (int i = 0; i < 6; i++) begin
      stop <= (i == 0);
      contactor <= (i != 1);
      conv <= (i == 2);
      decel <= (i == 3);
      hi_i <= (i != 5);
      wr(OFF_IN_LEVEL, (i == 4) ? 32'd100 : 32'd7);
      repeat (600) @(posedge clk);
      chk({31'h0, in_flt}, 32'h0);
    end
    rdchk(OFF_RIPPLE, 32'd100);
    $display("test input_suppression done");
    // Release suppression and time the input fault against four intervals.
    stop <= 1'b1;
    hi_i <= 1'b1;
    wr(OFF_IN_DELAY, 32'd4);
    stop <= 1'b0;
    rise_in(1'b0, 290, 430);
    @(posedge clk);
    chk({31'h0, coast}, 32'h1);
    rdchk(OFF_STATE, 32'h25);
    vamp <= 16'd0;
    repeat (400) @(posedge clk);
    chk({31'h0, in_flt}, 32'h1);
    rdchk(OFF_IRQ_STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_STS, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_FAULT_CLR, 32'h1);
    repeat (3) @(posedge clk);
    chk({30'h0, in_flt, coast}, 32'h0);
    $display("test input_fault done");
    // Output check: disabled settings, healthy current, then a real loss.
    for (int j = 0; j < 3; j++) begin
      hi_i <= (j == 2);
      wr(OFF_OUT_LEVEL, (j == 1) ? 32'd0 : 32'd50);
      wr(OFF_OUT_DELAY, (j == 0) ? 32'd0 : 32'd2);
      repeat (300) @(posedge clk);
      chk({31'h0, out_flt}, 32'h0);
    end
    hi_i <= 1'b0;
    rise_in(1'b1, 40, 130);
    repeat (3) @(posedge clk);
    chk({30'h0, coast, irq}, 32'h3);
    rdchk(OFF_IRQ_STS, 32'h2);
    wr(OFF_OUT_DELAY, 32'd0);
    wr(OFF_FAULT_CLR, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, out_flt}, 32'h0);
    $display("test output_fault done");
    conclude();
  end
endmodule
